/* core/step_cmd_decoder.sv */
// command-mode decoder: takes network output words, fires command
// pulses on rising command bits, serves the status words back.
// assumes the network side and motion engine run on clk_sys.
module step_cmd_decoder
    import step_cmd_pkg::*;
(
    input  wire logic           clk_sys,
    input  wire logic           rst,
    input  word_write_type      net_wr,
    input  wire logic           rd_en,
    input  wire logic [15:0]    rd_addr,
    input  wire logic           config_valid,
    input  wire logic           encoder_fitted,
    input  wire logic           net_prox_cfg,
    input  wire logic           home_pin,
    input  wire logic           move_busy,
    input  wire logic           move_done,
    output logic [15:0]         rd_data,
    output logic                rd_valid,
    output cmd_pulse_type       cmd,
    output logic signed [31:0]  position,
    output logic [15:0]         dwell_ms,
    output logic                driver_enable,
    output logic                config_mode,
    output logic                home_event,
    output logic                move_complete,
    output logic                pos_invalid,
    output logic                held,
    output logic                data_error,
    output logic [15:0]         error_code
);
    logic [15:0]        word_mem [WORD_COUNT];
    logic               load_high;
    logic [15:0]        high_level;
    logic [15:0]        high_rise;
    logic               home_meta;
    logic               home_sync;
    logic [0:0]         home_level;
    logic [0:0]         home_rise;
    logic signed [31:0] combined;
    logic               combined_ok;
    logic [15:0]        fire;
    logic               accept;
    logic               needs_pos;
    logic               starts_move;
    logic               prox_ok;
    logic [3:0]         word_idx;
    logic [3:0]         rd_idx;

    // address decode of the output word window
    always_comb begin
        word_idx  = 4'h0;
        load_high = 1'b0;
        if (net_wr.wr_en && net_wr.wr_addr >= OUT_BASE
                && net_wr.wr_addr <= ADDR_LAST) begin
            word_idx  = 4'(net_wr.wr_addr - OUT_BASE);
            load_high = (net_wr.wr_addr == ADDR_HIGH);
        end
    end

    // output word store, ten words
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < WORD_COUNT; i++) begin
                word_mem[i] <= 16'h0000;
            end
        end else if (net_wr.wr_en && net_wr.wr_addr >= OUT_BASE
                && net_wr.wr_addr <= ADDR_LAST) begin
            word_mem[word_idx] <= net_wr.wr_data;
        end
    end

    // edges of the high word, mode bit included
    rise_detect #(.WIDTH(16)) u_high (
        .clk_sys (clk_sys),
        .rst     (rst),
        .load    (load_high),
        .data    (net_wr.wr_data),
        .level   (high_level),
        .rise    (high_rise)
    );

    // two-word position parameter
    split_combine u_pos (
        .upper (word_mem[WORD_POS_UP]),
        .lower (word_mem[WORD_POS_LO]),
        .value (combined),
        .valid (combined_ok)
    );

    // clear errors reruns motion bits still set
    always_comb begin
        fire = high_rise;
        if (high_rise[HB_CLR]) begin
            fire = high_rise | (high_level & MOTION_MASK);
        end
        needs_pos = fire[HB_TARGET] | fire[HB_INCR] | fire[HB_MPOS]
                    | (fire[HB_EPOS] & encoder_fitted);
        // out-of-range lower word rejects a command that needs a position
        accept = config_valid && !high_level[HB_MODE]
                 && !(needs_pos && !combined_ok);
        starts_move = |(fire & MOTION_MASK);
    end

    // command pulses towards the motion engine
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmd      <= '0;
            position <= 32'sh0000_0000;
            dwell_ms <= 16'h0000;
        end else begin
            cmd <= '0;
            if (accept) begin
                cmd.target_motion        <= fire[HB_TARGET];
                cmd.incremental_motion   <= fire[HB_INCR];
                cmd.pause_motion         <= fire[HB_PAUSE];
                cmd.continue_held_motion <= fire[HB_CONTINUE]
                                            & held;
                cmd.immediate_stop       <= fire[HB_ISTOP];
                cmd.home_cw              <= fire[HB_HOME_CW];
                cmd.home_ccw             <= fire[HB_HOME_CCW];
                cmd.jog_cw               <= fire[HB_JOG_CW];
                cmd.jog_counter_clockwise <= fire[HB_JOG_CCW];
                cmd.registration <= word_mem[1][LB_REGISTER]
                    & (fire[HB_JOG_CW] | fire[HB_JOG_CCW]);
                cmd.motor_position_load  <= fire[HB_MPOS];
                cmd.clear_all_errors     <= fire[HB_CLR];
                cmd.program_sequence     <= fire[HB_PRG];
                cmd.program_sequence_segment <= fire[HB_PRG_SEG];
                cmd.run_stored_sequence  <= fire[HB_RUN_SEQ];
                cmd.dwell_sequence <= fire[HB_RUN_SEQ]
                    & word_mem[1][LB_DWELL];
                cmd.blend_ccw <= fire[HB_RUN_SEQ]
                    & ~word_mem[1][LB_DWELL]
                    & word_mem[1][LB_BLEND_CCW];
                cmd.encoder_position_load <= fire[HB_EPOS]
                    & encoder_fitted;
                cmd.cancel_held <= held & starts_move
                    & ~fire[HB_CONTINUE];
                if (needs_pos) begin
                    position <= combined;
                end
                if (fire[HB_RUN_SEQ]) begin
                    dwell_ms <= word_mem[WORD_DWELL];
                end
            end
        end
    end

    // hold state: a new move, continue or immediate stop ends it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            held <= 1'b0;
        end else if (accept && fire[HB_PAUSE] && move_busy) begin
            held <= 1'b1;
        end else if (accept && (starts_move || fire[HB_CONTINUE]
                || fire[HB_ISTOP])) begin
            held <= 1'b0;
        end
    end

    // move complete: completion wins over the clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            move_complete <= 1'b0;
        end else if (move_done) begin
            move_complete <= 1'b1;
        end else if (accept && (fire[HB_CLR] || fire[HB_MPOS])) begin
            move_complete <= 1'b0;
        end
    end

    // position invalid only when stopped during motion
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pos_invalid <= 1'b0;
        end else if (accept && fire[HB_ISTOP] && move_busy) begin
            pos_invalid <= 1'b1;
        end else if (accept && fire[HB_MPOS]) begin
            pos_invalid <= 1'b0;
        end
    end

    // rejected two-word data flag, set wins over clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            data_error <= 1'b0;
        end else if (needs_pos && !combined_ok) begin
            data_error <= 1'b1;
        end else if (high_rise[HB_CLR] && config_valid) begin
            data_error <= 1'b0;
        end
    end

    // drive enable, mode and status code
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            driver_enable <= 1'b0;
            config_mode   <= 1'b0;
            error_code    <= STATUS_UNCONFIGURED;
        end else begin
            driver_enable <= word_mem[1][LB_DRIVE]
                             & config_valid;
            config_mode   <= high_level[HB_MODE];
            error_code    <= config_valid ? STATUS_IDLE
                             : STATUS_UNCONFIGURED;
        end
    end

    // home pin synchroniser
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            home_meta <= 1'b0;
            home_sync <= 1'b0;
        end else begin
            home_meta <= home_pin;
            home_sync <= home_meta;
        end
    end

    rise_detect #(.WIDTH(1)) u_home (
        .clk_sys (clk_sys),
        .rst     (rst),
        .load    (1'b1),
        .data    (home_sync),
        .level   (home_level),
        .rise    (home_rise)
    );

    assign prox_ok = !net_prox_cfg || word_mem[1][LB_PROX];

    // home rising edges pass only with proximity when net_prox_cfg is set, always otherwise
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            home_event <= 1'b0;
        end else begin
            home_event <= home_rise[0] & prox_ok;
        end
    end

    // input word read port, registered
    always_comb begin
        rd_idx = 4'(rd_addr - IN_BASE);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_data  <= 16'h0000;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            rd_data  <= 16'h0000;
            if (rd_en && rd_addr >= IN_BASE && rd_addr <= IN_LAST) begin
                if (rd_idx == IN_STATUS) begin
                    rd_data <= error_code;
                end else if (rd_idx == IN_FLAGS) begin
                    rd_data <= {10'h000, data_error, held, pos_invalid,
                                move_complete, driver_enable, config_mode};
                end
            end
        end
    end

    property p_drive_gate;
        @(posedge clk_sys) disable iff (rst)
        driver_enable |-> $past(config_valid);
    endproperty
    a_drive_gate: assert property (p_drive_gate)
        else $error("drive enabled without configuration");

    property p_no_cmd_unconfigured;
        @(posedge clk_sys) disable iff (rst)
        !config_valid ##1 1'b1 |-> !cmd.target_motion && !cmd.jog_cw;
    endproperty
    a_no_cmd_unconfigured: assert property (p_no_cmd_unconfigured)
        else $error("command taken while unconfigured");

    property p_status_code;
        @(posedge clk_sys) disable iff (rst)
        !config_valid [*2] |-> error_code == STATUS_UNCONFIGURED;
    endproperty
    a_status_code: assert property (p_status_code)
        else $error("unconfigured status code missing");

    property p_pulse_once;
        @(posedge clk_sys) disable iff (rst)
        cmd.incremental_motion |=> !cmd.incremental_motion;
    endproperty
    a_pulse_once: assert property (p_pulse_once)
        else $error("command pulse longer than one cycle");

    property p_stop_invalid;
        @(posedge clk_sys) disable iff (rst)
        accept && fire[HB_ISTOP] && move_busy |=> pos_invalid;
    endproperty
    a_stop_invalid: assert property (p_stop_invalid)
        else $error("stop during move left position valid");

    property p_home_gate;
        @(posedge clk_sys) disable iff (rst)
        home_event |-> $past(prox_ok);
    endproperty
    a_home_gate: assert property (p_home_gate)
        else $error("home event without proximity");

    property p_cancel_held;
        @(posedge clk_sys) disable iff (rst)
        cmd.cancel_held |-> !held && $past(held);
    endproperty
    a_cancel_held: assert property (p_cancel_held)
        else $error("held move not cancelled");

    property p_position_value;
        @(posedge clk_sys) disable iff (rst)
        cmd.motor_position_load |-> position == $past(combined)
            && !pos_invalid;
    endproperty
    a_position_value: assert property (p_position_value)
        else $error("loaded position differs from combined value");

    property p_complete_cleared;
        @(posedge clk_sys) disable iff (rst)
        cmd.motor_position_load && !$past(move_done) |-> !move_complete;
    endproperty
    a_complete_cleared: assert property (p_complete_cleared)
        else $error("move complete not cleared by position load");
endmodule : step_cmd_decoder

/* core/step_cmd_pkg.sv */
// package for the network command decoder: word map, bit
// positions, status codes and the carrier structs.
// assumes one 50 MHz system clock shared by all users.
package step_cmd_pkg;
    localparam int          WORD_COUNT       = 10;
    localparam logic [15:0] OUT_BASE         = 16'h0400;
    localparam logic [15:0] ADDR_HIGH        = 16'h0400;
    localparam logic [15:0] ADDR_LOW         = 16'h0401;
    localparam logic [15:0] ADDR_LAST        = 16'h0409;
    localparam logic [15:0] IN_BASE          = 16'h0000;
    localparam logic [15:0] IN_LAST          = 16'h0009;
    localparam logic [3:0]  IN_STATUS        = 4'h0;
    localparam logic [3:0]  IN_FLAGS         = 4'h1;
    localparam int          WORD_POS_UP      = 2;
    localparam int          WORD_POS_LO      = 3;
    localparam int          WORD_DWELL       = 9;
    localparam logic signed [31:0] SPLIT_SCALE = 32'sh0000_03E8;
    localparam logic signed [15:0] LOWER_MAX   = 16'sh03E7;
    localparam logic signed [15:0] LOWER_MIN   = -16'sh03E7;
    // high command word bit positions
    localparam int HB_TARGET   = 0;
    localparam int HB_INCR     = 1;
    localparam int HB_PAUSE    = 2;
    localparam int HB_CONTINUE = 3;
    localparam int HB_ISTOP    = 4;
    localparam int HB_HOME_CW  = 5;
    localparam int HB_HOME_CCW = 6;
    localparam int HB_JOG_CW   = 7;
    localparam int HB_JOG_CCW  = 8;
    localparam int HB_MPOS     = 9;
    localparam int HB_CLR      = 10;
    localparam int HB_PRG      = 11;
    localparam int HB_PRG_SEG  = 12;
    localparam int HB_RUN_SEQ  = 13;
    localparam int HB_EPOS     = 14;
    localparam int HB_MODE     = 15;
    // low command word bit positions
    localparam int LB_BLEND_CCW = 4;
    localparam int LB_REGISTER  = 7;
    localparam int LB_DWELL     = 9;
    localparam int LB_PROX      = 11;
    localparam int LB_DRIVE     = 15;
    // commands that start a motion
    localparam logic [15:0] MOTION_MASK = 16'h21E3;
    localparam logic [15:0] STATUS_UNCONFIGURED = 16'h6408;
    localparam logic [15:0] STATUS_IDLE         = 16'h0000;

    typedef struct packed {
        logic target_motion;
        logic incremental_motion;
        logic pause_motion;
        logic continue_held_motion;
        logic immediate_stop;
        logic home_cw;
        logic home_ccw;
        logic jog_cw;
        logic jog_counter_clockwise;
        logic registration;
        logic motor_position_load;
        logic clear_all_errors;
        logic program_sequence;
        logic program_sequence_segment;
        logic run_stored_sequence;
        logic dwell_sequence;
        logic blend_ccw;
        logic encoder_position_load;
        logic cancel_held;
    } cmd_pulse_type;

    typedef struct packed {
        logic               wr_en;
        logic [15:0]        wr_addr;
        logic [15:0]        wr_data;
    } word_write_type;
endpackage : step_cmd_pkg

/* core/rise_detect.sv */
// registered level and rising-edge pulse of a loaded word.
// assumes load and data come from logic on the same clock.
module rise_detect
    import step_cmd_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] data,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise
);
    // a bit fires only on a zero to one change between loads
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            level <= '0;
            rise  <= '0;
        end else if (load) begin
            level <= data;
            rise  <= data & ~level;
        end else begin
            rise  <= '0;
        end
    end
endmodule : rise_detect

/* core/split_combine.sv */
// rebuilds a value carried as upper and lower signed words.
// assumes lower holds the three least significant digits.
module split_combine
    import step_cmd_pkg::*;
(
    input  wire logic signed [15:0] upper,
    input  wire logic signed [15:0] lower,
    output logic signed [31:0]      value,
    output logic                    valid
);
    logic signed [31:0] up_ext;
    logic signed [31:0] lo_ext;
    logic signed [63:0] prod;

    // value = upper * 1000 + lower, signs must agree
    always_comb begin
        up_ext = {{16{upper[15]}}, upper};
        lo_ext = {{16{lower[15]}}, lower};
        prod   = up_ext * SPLIT_SCALE;
        value  = prod[31:0] + lo_ext;
        valid  = (lower <= LOWER_MAX) && (lower >= LOWER_MIN)
                 && !(upper[15] && (lower > 16'sh0000))
                 && !(lower[15] && (upper > 16'sh0000));
    end
endmodule : split_combine

/* test/net_host_model.sv */
// host model: writes network output words, one per write cycle.
// assumes the decoder samples net_wr on the rising clk_sys edge.
module net_host_model
    import step_cmd_pkg::*;
(
    input  wire logic      clk_sys,
    output word_write_type net_wr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial net_wr = '0;

    // one word, held until the sampling edge, then released
    task automatic put(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        net_wr <= '{1'b1, a, d};
        @(posedge clk_sys);
        net_wr.wr_en <= 1'b0;
    endtask : put

    // parameters and low word first, high word last, then cleared
    task automatic command(input logic [15:0] hi, input logic [15:0] lo,
                           input logic [15:0] up, input logic [15:0] dn);
        put(ADDR_LOW, lo & 16'h8FFF);
        put(OUT_BASE + 16'h0002, up);
        put(OUT_BASE + 16'h0003, dn);
        put(ADDR_HIGH, hi);
        put(ADDR_HIGH, 16'h0000);
    endtask : command
endmodule : net_host_model

/* test/step_cmd_decoder_bench.sv */
// bench for the network command decoder: scenarios drive the host
// model and motion inputs, then judge pulses and status outputs.
// assumes a 50 MHz clk_sys and the host model net_host_model.
module step_cmd_decoder_bench
    import step_cmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst, rd_en, rd_valid, cfg, enc, prox, home, busy, done;
    logic [15:0] rd_addr, rd_data, dwell_ms, error_code;
    logic drv, cmode, hev, mcomp, pinv, held, derr, hseen;
    logic signed [31:0] position;
    word_write_type net_wr;
    cmd_pulse_type  cmd, seen;
    int miscompares = 0;
    int cmp_count = 0;

    net_host_model host_i (.clk_sys(clk_sys), .net_wr(net_wr));
    step_cmd_decoder step_cmd_decoder_i (
        .clk_sys(clk_sys), .rst(rst), .net_wr(net_wr), .rd_en(rd_en),
        .rd_addr(rd_addr), .config_valid(cfg), .encoder_fitted(enc),
        .net_prox_cfg(prox), .home_pin(home), .move_busy(busy),
        .move_done(done), .rd_data(rd_data), .rd_valid(rd_valid),
        .cmd(cmd), .position(position), .dwell_ms(dwell_ms),
        .driver_enable(drv), .config_mode(cmode), .home_event(hev),
        .move_complete(mcomp), .pos_invalid(pinv), .held(held),
        .data_error(derr), .error_code(error_code));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // sticky capture of one-cycle pulses
    always @(posedge clk_sys) begin
        seen  <= seen | cmd;
        hseen <= hseen | hev;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic flag(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask : flag

    // full command with parameters, pulses gathered afresh
    task automatic go(input logic [15:0] hi, input logic [15:0] lo,
                      input logic [15:0] up, input logic [15:0] dn);
        #1 seen = '0;
        host_i.command(hi, lo, up, dn);
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : go

    task automatic hi_only(input logic [15:0] hi);
        #1 seen = '0;
        host_i.put(ADDR_HIGH, hi);
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : hi_only

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        rd_en   <= 1'b1;
        rd_addr <= a;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 flag(rd_valid, 1'b1);
        check({16'h0, rd_data}, {16'h0, exp});
    endtask : rd

    task automatic t_unconfigured();
        rd(16'h0000, STATUS_UNCONFIGURED);
        go(16'h0001, 16'h8000, 16'h0000, 16'h0005);
        flag(seen.target_motion, 1'b0);
        flag(drv, 1'b0);
        check({16'h0, error_code}, {16'h0, STATUS_UNCONFIGURED});
        @(posedge clk_sys);
        cfg <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 flag(drv, 1'b1);
        check({16'h0, error_code}, {16'h0, STATUS_IDLE});
        rd(16'h0000, STATUS_IDLE);
        $display("test unconfigured done");
    endtask : t_unconfigured

    task automatic t_target();
        go(16'h0001, 16'h8000, -16'sd7654, -16'sd321);
        flag(seen.target_motion, 1'b1);
        check(position, -32'sd7654321);
        hi_only(16'h0001);
        hi_only(16'h0001);
        flag(seen.target_motion, 1'b0);
        hi_only(16'h0000);
        go(16'h0002, 16'h8000, 16'h0001, 16'h03E8);
        flag(seen.incremental_motion, 1'b0);
        flag(derr, 1'b1);
        go(16'h0002, 16'h8000, 16'h0002, 16'h0003);
        flag(seen.incremental_motion, 1'b1);
        check(position, 32'sd2003);
        $display("test target done");
    endtask : t_target

    task automatic t_mode();
        hi_only(16'h8001);
        flag(cmode, 1'b1);
        flag(seen.target_motion, 1'b0);
        hi_only(16'h0001);
        flag(cmode, 1'b0);
        flag(seen.target_motion, 1'b0);
        hi_only(16'h0000);
        @(posedge clk_sys);
        done <= 1'b1;
        @(posedge clk_sys);
        done <= 1'b0;
        go(16'h0400, 16'h8000, 16'h0000, 16'h0000);
        flag(seen.clear_all_errors, 1'b1);
        flag(derr, 1'b0);
        flag(mcomp, 1'b0);
        hi_only(16'h0001);
        hi_only(16'h0401);
        flag(seen.target_motion, 1'b1);
        hi_only(16'h0000);
        $display("test mode done");
    endtask : t_mode

    task automatic t_hold();
        @(posedge clk_sys);
        busy <= 1'b1;
        go(16'h0004, 16'h8000, 16'h0000, 16'h0000);
        flag(held, 1'b1);
        flag(seen.pause_motion, 1'b1);
        go(16'h0008, 16'h8000, 16'h0000, 16'h0000);
        flag(seen.continue_held_motion, 1'b1);
        go(16'h0004, 16'h8000, 16'h0000, 16'h0000);
        go(16'h0080, 16'h8000, 16'h0000, 16'h0000);
        flag(seen.cancel_held, 1'b1);
        flag(seen.jog_cw, 1'b1);
        go(16'h0010, 16'h8000, 16'h0000, 16'h0000);
        flag(pinv, 1'b1);
        go(16'h0200, 16'h8000, 16'h0000, 16'h000C);
        check(position, 32'sd12);
        flag(pinv, 1'b0);
        @(posedge clk_sys);
        busy <= 1'b0;
        go(16'h0010, 16'h8000, 16'h0000, 16'h0000);
        flag(seen.immediate_stop, 1'b1);
        flag(pinv, 1'b0);
        $display("test hold done");
    endtask : t_hold

    task automatic t_misc();
        host_i.put(OUT_BASE + 16'h0009, 16'h1388);
        go(16'h2000, 16'h8210, 16'h0000, 16'h0000);
        flag(seen.dwell_sequence, 1'b1);
        flag(seen.blend_ccw, 1'b0);
        check({16'h0, dwell_ms}, 32'h0000_1388);
        go(16'h2000, 16'h8010, 16'h0000, 16'h0000);
        flag(seen.run_stored_sequence, 1'b1);
        flag(seen.dwell_sequence, 1'b0);
        flag(seen.blend_ccw, 1'b1);
        go(16'h1800, 16'h8000, 16'h0000, 16'h0000);
        flag(seen.program_sequence, 1'b1);
        flag(seen.program_sequence_segment, 1'b1);
        go(16'h0100, 16'h8080, 16'h0000, 16'h0000);
        flag(seen.jog_counter_clockwise, 1'b1);
        flag(seen.registration, 1'b1);
        go(16'h0040, 16'h8000, 16'h0000, 16'h0000);
        flag(seen.home_ccw, 1'b1);
        go(16'h0020, 16'h8000, 16'h0000, 16'h0000);
        flag(seen.home_cw, 1'b1);
        @(posedge clk_sys);
        enc <= 1'b1;
        go(16'h4000, 16'h8000, 16'h0001, 16'h0002);
        check(position, 32'sd1002);
        $display("test misc done");
    endtask : t_misc

    task automatic t_home(input logic [15:0] lo, input logic exp);
        host_i.put(ADDR_LOW, lo);
        home <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 hseen = 1'b0;
        @(posedge clk_sys);
        home <= 1'b1;
        repeat (8) @(posedge clk_sys);
        #1 flag(hseen, exp);
        $display("test home done");
    endtask : t_home

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    // watchdog sized well beyond the scenario run time
    initial begin
        #200us;
        miscompares++;
        complete_run();
    end

    initial begin
        {rst, rd_en, cfg, enc, prox, home, busy, done} = 8'h80;
        rd_addr = 16'h0000;
        seen    = '0;
        hseen   = 1'b0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        t_unconfigured();
        t_target();
        t_mode();
        t_hold();
        t_misc();
        @(posedge clk_sys);
        prox <= 1'b1;
        t_home(16'h8000, 1'b0);
        t_home(16'h8800, 1'b1);
        complete_run();
    end
endmodule : step_cmd_decoder_bench
